/* File: sim/test_global_clock_reset_irq_regs.sv */
`timescale 1ns/10ps
module test_global_clock_reset_irq_regs;
  import gcr_pkg::*;
  localparam int BP_DIV = 10; // backplane period in system cycles
  logic clk_sys_in, reset_in, wr_in, rd_in, irq_out, bp_clk, bp_en, sync_pin_in, hi;
  logic freeze_sel, sync_pin_out, sync_oe_n, frame_pulse, freq_sel, bfreq_sel;
  logic [11:0] addr_in;
  logic [7:0] wdata_in, rdata_out, line_loss, framer_loss, sig_freeze, alarm;
  logic [7:0] tester_irq, line_irq, lu_rst, lu_pls, ft_rst, ft_pls, v, old, lv, tv;
  logic [1:0] mps;
  logic [3:0] bpref;
  int bad_count, n_checks, n;

  global_clock_reset_irq_regs u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .backplane_clock_in(bp_clk),
    .sync_pin_in(sync_pin_in), .sync_pin_out(sync_pin_out), .sync_pin_oe_n_out(sync_oe_n),
    .frame_pulse_out(frame_pulse), .line_loss_in(line_loss), .framer_loss_in(framer_loss),
    .sig_freeze_in(sig_freeze), .freeze_select_in(freeze_sel), .alarm_output_pins_out(alarm),
    .master_period_select_out(mps), .frequency_select_out(freq_sel),
    .backplane_frequency_select_out(bfreq_sel), .backplane_reference_select_out(bpref),
    .line_unit_reset_out(lu_rst), .line_unit_reset_pulse_out(lu_pls),
    .framer_tester_reset_out(ft_rst), .framer_tester_reset_pulse_out(ft_pls),
    .tester_irq_in(tester_irq), .line_unit_irq_in(line_irq));

  // system clock, 40 ns
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // backplane clock, offset so it never lines up with system edges
  initial begin
    bp_clk = 1'b0;
    #7;
    forever #(BP_DIV * 20) bp_clk = bp_en ? ~bp_clk : 1'b0;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask

  // one-cycle write strobe; returns once its effect has landed
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    check(rdata_out, exp);
  endtask

  // counts cycles to the next frame mark, noting any driven sync level
  task automatic wait_frame(output int cnt);
    cnt = 0;
    do begin
      tick(1);
      cnt++;
      hi = hi | (sync_pin_out === 1'b1);
    end while (frame_pulse !== 1'b1 && cnt < 6000);
  endtask

  function automatic logic [7:0] alarm_exp(input logic src, input logic fs,
      input logic [7:0] ln, input logic [7:0] fr, input logic [7:0] fz);
    return fs ? fz : (src ? ln : fr);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog: the whole sequence needs about 9300 cycles
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    bad_count++;
    test_done();
  end

  logic [11:0] u_addr [6] = '{OFF_SYNC_LOSS, OFF_CLK_FREQ, OFF_LINE_RST, OFF_FRM_RST,
    OFF_TESTER_SUM, OFF_LINE_SUM};

  initial begin
    {reset_in, wr_in, rd_in, addr_in, wdata_in, bp_en, sync_pin_in, freeze_sel} = '0;
    {line_loss, framer_loss, sig_freeze, tester_irq, line_irq, hi} = '0;
    reset_in = 1'b1;
    void'($urandom(32'hACF13406));
    repeat (12) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    foreach (u_addr[i]) rd_chk(u_addr[i], RST_REG);
    check({7'h00, sync_oe_n}, 8'h01);
    // clock control fields, corners then random
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? {8{i[0]}} : 8'($urandom);
      reg_wr(OFF_CLK_FREQ, v);
      check({freq_sel, bfreq_sel, mps, bpref}, {v[2], v[3], v[1:0], v[7:4]});
      rd_chk(OFF_CLK_FREQ, v);
    end
    // every loss source, direction and freeze combination
    for (int i = 0; i < 8; i++) begin
      v = (8'($urandom) & 8'hF9) | {5'h00, i[0], i[1], 1'b0};
      reg_wr(OFF_SYNC_LOSS, v);
      @(posedge clk_sys_in);
      line_loss <= 8'($urandom);
      framer_loss <= 8'($urandom);
      sig_freeze <= 8'($urandom);
      freeze_sel <= i[2];
      tick(2);
      check(alarm, alarm_exp(i[0], i[2], line_loss, framer_loss, sig_freeze));
      check({7'h00, sync_oe_n}, {7'h00, ~i[1]});
      rd_chk(OFF_SYNC_LOSS, v & 8'h06);
    end
    // soft resets: pulse only on rising bits, level held until zero written
    for (int r = 0; r < 2; r++) begin
      old = 8'h00;
      for (int i = 0; i < 5; i++) begin
        v = (i == 1) ? 8'hFF : (i == 4) ? 8'h00 : 8'($urandom);
        reg_wr(r ? OFF_FRM_RST : OFF_LINE_RST, v);
        check(r ? ft_pls : lu_pls, v & ~old);
        check(r ? ft_rst : lu_rst, v);
        tick(1);
        check(r ? ft_pls : lu_pls, 8'h00);
        old = v;
      end
    end
    // summaries follow sources and ignore writes; a zero step makes bit 7 fall
    for (int i = 0; i < 5; i++) begin
      tv = (i == 0) ? 8'h80 : (i == 4) ? 8'h00 : 8'($urandom);
      lv = (i == 0) ? 8'h80 : (i == 1 || i == 4) ? 8'h00 : 8'($urandom);
      @(posedge clk_sys_in);
      tester_irq <= tv;
      line_irq <= lv;
      reg_wr(OFF_LINE_SUM, ~lv);
      reg_wr(OFF_TESTER_SUM, ~tv);
      rd_chk(OFF_TESTER_SUM, tv);
      rd_chk(OFF_LINE_SUM, lv);
    end
    tick(1);
    check(rdata_out, RD_UNMAPPED);
    reg_wr(12'h0F4, 8'hA5);
    rd_chk(12'h0F4, RD_UNMAPPED);
    rd_chk(12'h100, RD_UNMAPPED);
    // interrupt: raise while masked, unmask, clear
    reg_wr(OFF_EVT_MASK, 8'h00);
    reg_wr(OFF_EVT_STATUS, 8'h0F);
    rd_chk(OFF_EVT_STATUS, 8'h00);
    @(posedge clk_sys_in);
    line_irq <= 8'h04;
    tick(3);
    rd_chk(OFF_EVT_STATUS, 8'h02);
    check({7'h00, irq_out}, 8'h00);
    reg_wr(OFF_EVT_MASK, 8'h0A);
    tick(1);
    check({7'h00, irq_out}, 8'h01);
    reg_wr(OFF_EVT_STATUS, 8'h02);
    tick(1);
    check({7'h00, irq_out}, 8'h00);
    reg_wr(OFF_LINE_RST, 8'h01);
    tick(1);
    check({7'h00, irq_out}, 8'h01);
    reg_wr(OFF_LINE_RST, 8'h00);
    reg_wr(OFF_EVT_STATUS, 8'h0F);
    // a new line event in the very cycle of its clear must survive it
    fork
      reg_wr(OFF_EVT_STATUS, 8'h02);
      begin
        @(posedge clk_sys_in);
        line_irq <= 8'h0C;
      end
    join
    rd_chk(OFF_EVT_STATUS, 8'h02);
    reg_wr(OFF_EVT_STATUS, 8'h0F);
    rd_chk(OFF_EVT_MASK, 8'h0A);
    // input mode: outside pulse becomes a frame mark, pin never driven
    reg_wr(OFF_SYNC_LOSS, 8'h00);
    hi = 1'b0;
    @(posedge clk_sys_in);
    sync_pin_in <= 1'b1;
    wait_frame(n);
    check(8'(n < 10), 8'h01);
    check({7'h00, hi}, 8'h00);
    @(posedge clk_sys_in);
    sync_pin_in <= 1'b0;
    // output mode: frame spacing and pulse width for both backplane references
    reg_wr(OFF_SYNC_LOSS, 8'h02);
    bp_en = 1'b1;
    for (int f = 0; f < 2; f++) begin
      reg_wr(OFF_CLK_FREQ, f ? 8'h08 : 8'h00);
      wait_frame(n);
      wait_frame(n);
      check(8'(n == (f ? BP_T1_KHZ : BP_E1_KHZ) / FRAME_KHZ * BP_DIV), 8'h01);
      check({7'h00, sync_pin_out}, 8'h01);
      tick(BP_DIV - 1);
      check({7'h00, sync_pin_out}, 8'h01);
      tick(1);
      check({7'h00, sync_pin_out}, 8'h00);
    end
    check({7'h00, hi}, 8'h01);
    test_done();
  end
endmodule

/* File: src/gcr_pkg.sv */
package gcr_pkg;
  // register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int CHAN_N = 8;

  // register offsets
  localparam logic [11:0] OFF_SYNC_LOSS = 12'h0F2;
  localparam logic [11:0] OFF_CLK_FREQ = 12'h0F3;
  localparam logic [11:0] OFF_LINE_RST = 12'h0F5;
  localparam logic [11:0] OFF_FRM_RST = 12'h0F6;
  localparam logic [11:0] OFF_EVT_STATUS = 12'h0F7;
  localparam logic [11:0] OFF_EVT_MASK = 12'h0F8;
  localparam logic [11:0] OFF_TESTER_SUM = 12'h0FA;
  localparam logic [11:0] OFF_LINE_SUM = 12'h0FB;

  // field positions, sync/loss register
  localparam int BIT_SYNC_DIR = 1;
  localparam int BIT_LOSS_SRC = 2;
  // field positions, clock frequency register
  localparam int POS_MPS_LO = 0;
  localparam int BIT_FREQUENCY_SELECT = 2;
  localparam int BIT_BACKPLANE_FREQUENCY_SELECT = 3;
  localparam int POS_BPREF_LO = 4;

  // event status bit positions
  localparam int EVT_TESTER = 0;
  localparam int EVT_LINE = 1;
  localparam int EVT_FRAME = 2;
  localparam int EVT_RESET = 3;
  localparam int EVT_N = 4;

  // reset value and unmapped-read value
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // frame timing, frequencies in kHz
  localparam int FRAME_KHZ = 8;
  localparam int BP_E1_KHZ = 2048;
  localparam int BP_T1_KHZ = 1544;
  localparam logic [8:0] FRAME_CNT_E1 = 9'(BP_E1_KHZ / FRAME_KHZ);
  localparam logic [8:0] FRAME_CNT_T1 = 9'(BP_T1_KHZ / FRAME_KHZ);
  localparam logic [8:0] FRAME_CNT_RST = 9'h000;
endpackage

/* File: src/global_clock_reset_irq_regs.sv */
`timescale 1ns/10ps
// Overview of operation
// - sync direction one: drive 8 kHz frame pulse on sync pin, timed by backplane clock.
// - sync direction zero: sync pin is input; outside supplies the 8 kHz pulse.
// - loss source one selects line unit loss, zero framer loss, on alarm pins.
// - loss source applies to all eight ports; framer control picks loss or freeze.
// - master period field plus frequency bit tell the assumed master clock.
// - frequency bit zero means 2.048 MHz family, one means 1.544 MHz family.
// - backplane frequency bit: zero 2.048 MHz reference, one 1.544 MHz reference.
// - four-bit reference field chooses backplane clock source.
// - line unit reset bit n resets channel n+1 line unit on rising write.
// - channel soft reset stays asserted until software writes zero.
// - framer reset bit n resets channel n+1 framer and tester on rising write.
// - tester summary: bit n reads one while tester n+1 has an interrupt.
// - line unit summary: bit n reads one while unit n+1 has an interrupt.
// - line unit summary encoding continues to bit 7 for unit 8.
module global_clock_reset_irq_regs
  import gcr_pkg::*;
(
  input wire logic clk_sys_in, // 25 MHz system clock
  input wire logic reset_in, // synchronous, active high
  input wire logic [11:0] addr_in, // register address
  input wire logic [7:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [7:0] rdata_out, // read data, cycle after strobe
  output logic irq_out, // level interrupt
  input wire logic backplane_clock_in, // backplane clock pin
  input wire logic sync_pin_in, // sync pin sensed level
  output logic sync_pin_out, // sync pin driven level
  output logic sync_pin_oe_n_out, // low while driving the pin
  output logic frame_pulse_out, // one-cycle frame mark
  input wire logic [7:0] line_loss_in, // line unit loss per port
  input wire logic [7:0] framer_loss_in, // framer loss per port
  input wire logic [7:0] sig_freeze_in, // signalling freeze per port
  input wire logic freeze_select_in, // framer control: freeze vs loss
  output logic [7:0] alarm_output_pins_out, // alarm pins per port
  output logic [1:0] master_period_select_out, // master period field
  output logic frequency_select_out, // master clock family
  output logic backplane_frequency_select_out, // backplane reference freq
  output logic [3:0] backplane_reference_select_out, // backplane source
  output logic [7:0] line_unit_reset_out, // per-channel reset level
  output logic [7:0] line_unit_reset_pulse_out, // per-channel reset start
  output logic [7:0] framer_tester_reset_out, // per-channel reset level
  output logic [7:0] framer_tester_reset_pulse_out, // per-channel reset start
  input wire logic [7:0] tester_irq_in, // tester pending interrupts
  input wire logic [7:0] line_unit_irq_in // line unit pending interrupts
);

  // address match, shared by write and read decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  logic [7:0] sync_loss_ff;
  logic [7:0] clk_freq_ff;
  logic [7:0] line_rst_ff;
  logic [7:0] frm_rst_ff;
  logic [7:0] line_rst_pulse_ff;
  logic [7:0] frm_rst_pulse_ff;
  logic [7:0] tester_sum_ff;
  logic [7:0] line_sum_ff;
  logic [EVT_N-1:0] evt_status_ff;
  logic [EVT_N-1:0] evt_mask_ff;
  logic [7:0] rdata_ff;
  logic [7:0] alarm_ff;
  logic [8:0] frame_cnt_ff;
  logic sync_out_ff;
  logic frame_pulse_ff;
  logic irq_ff;

  // write decode
  wire wr_sync_loss = wr_in && hit(addr_in, OFF_SYNC_LOSS);
  wire wr_clk_freq = wr_in && hit(addr_in, OFF_CLK_FREQ);
  wire wr_line_rst = wr_in && hit(addr_in, OFF_LINE_RST);
  wire wr_frm_rst = wr_in && hit(addr_in, OFF_FRM_RST);
  wire wr_evt_status = wr_in && hit(addr_in, OFF_EVT_STATUS);
  wire wr_evt_mask = wr_in && hit(addr_in, OFF_EVT_MASK);

  // control fields
  wire sync_dir = sync_loss_ff[BIT_SYNC_DIR];
  wire loss_src = sync_loss_ff[BIT_LOSS_SRC];
  wire bfreq = clk_freq_ff[BIT_BACKPLANE_FREQUENCY_SELECT];

  // configuration registers; the summary offsets have no write path at all
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sync_loss_ff <= RST_REG;
      clk_freq_ff <= RST_REG;
      evt_mask_ff <= '0;
    end else begin
      if (wr_sync_loss) begin
        sync_loss_ff <= wdata_in & 8'h06;
      end
      if (wr_clk_freq) begin
        clk_freq_ff <= wdata_in;
      end
      if (wr_evt_mask) begin
        evt_mask_ff <= wdata_in[EVT_N-1:0];
      end
    end
  end

  // clock selection fields go straight to the clock generator
  assign master_period_select_out = clk_freq_ff[POS_MPS_LO +: 2];
  assign frequency_select_out = clk_freq_ff[BIT_FREQUENCY_SELECT];
  assign backplane_frequency_select_out = bfreq;
  assign backplane_reference_select_out = clk_freq_ff[POS_BPREF_LO +: 4];

  // soft resets: level held until a zero is written; start marked on 0-to-1
  wire [7:0] nxt_line_rst = wr_line_rst ? wdata_in : line_rst_ff;
  wire [7:0] nxt_frm_rst = wr_frm_rst ? wdata_in : frm_rst_ff;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      line_rst_ff <= RST_REG;
      frm_rst_ff <= RST_REG;
      line_rst_pulse_ff <= RST_REG;
      frm_rst_pulse_ff <= RST_REG;
    end else begin
      line_rst_ff <= nxt_line_rst;
      frm_rst_ff <= nxt_frm_rst;
      line_rst_pulse_ff <= nxt_line_rst & ~line_rst_ff;
      frm_rst_pulse_ff <= nxt_frm_rst & ~frm_rst_ff;
    end
  end
  assign line_unit_reset_out = line_rst_ff;
  assign framer_tester_reset_out = frm_rst_ff;
  assign line_unit_reset_pulse_out = line_rst_pulse_ff;
  assign framer_tester_reset_pulse_out = frm_rst_pulse_ff;

  // interrupt summaries mirror the sources, so a cleared source drops its bit
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tester_sum_ff <= RST_REG;
      line_sum_ff <= RST_REG;
    end else begin
      tester_sum_ff <= tester_irq_in;
      line_sum_ff <= line_unit_irq_in;
    end
  end

  // pin synchronisers: backplane clock and sync pin, three stages each
  logic [1:0] pin_s1_ff;
  logic [1:0] pin_s2_ff;
  logic [1:0] pin_s3_ff;
  logic [1:0] pin_lvl_ff;
  logic [1:0] pin_rise;
  wire [1:0] pin_raw = {sync_pin_in, backplane_clock_in};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      // a change counts only when stages two and three agree
      wire stable = (pin_s2_ff[g] == pin_s3_ff[g]);
      always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
          pin_s1_ff[g] <= 1'b0;
          pin_s2_ff[g] <= 1'b0;
          pin_s3_ff[g] <= 1'b0;
          pin_lvl_ff[g] <= 1'b0;
        end else begin
          pin_s1_ff[g] <= pin_raw[g];
          pin_s2_ff[g] <= pin_s1_ff[g];
          pin_s3_ff[g] <= pin_s2_ff[g];
          if (stable) begin
            pin_lvl_ff[g] <= pin_s3_ff[g];
          end
        end
      end
      assign pin_rise[g] = stable && pin_s3_ff[g] && !pin_lvl_ff[g];
    end
  endgenerate
  wire bp_rise = pin_rise[0];
  wire sync_in_rise = pin_rise[1];

  // frame divider on backplane edges; period follows the reference frequency
  wire [8:0] frame_len = bfreq ? FRAME_CNT_T1 : FRAME_CNT_E1;
  wire frame_wrap = (frame_cnt_ff >= frame_len - 9'd1);
  wire [8:0] nxt_frame_cnt = frame_wrap ? FRAME_CNT_RST : 9'(frame_cnt_ff + 9'd1);
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      frame_cnt_ff <= FRAME_CNT_RST;
      sync_out_ff <= 1'b0;
    end else if (bp_rise) begin
      frame_cnt_ff <= nxt_frame_cnt;
      // pulse spans one backplane period, changing only on its edges while driving; input mode clears it at once
      sync_out_ff <= sync_dir && (nxt_frame_cnt == FRAME_CNT_RST);
    end else if (!sync_dir) begin
      sync_out_ff <= 1'b0;
    end
  end

  // pin direction; in input mode the outside must supply the pulse
  assign sync_pin_out = sync_out_ff;
  assign sync_pin_oe_n_out = !sync_dir;

  // frame mark for the transmit side from whichever source is active
  wire gen_frame = sync_dir && bp_rise && frame_wrap;
  wire ext_frame = !sync_dir && sync_in_rise;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      frame_pulse_ff <= 1'b0;
    end else begin
      frame_pulse_ff <= gen_frame || ext_frame;
    end
  end
  assign frame_pulse_out = frame_pulse_ff;

  // alarm pins: one select bit serves all eight ports
  wire [7:0] loss_pick = loss_src ? line_loss_in : framer_loss_in;
  wire [7:0] nxt_alarm = freeze_select_in ? sig_freeze_in : loss_pick;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      alarm_ff <= RST_REG;
    end else begin
      alarm_ff <= nxt_alarm;
    end
  end
  assign alarm_output_pins_out = alarm_ff;

  // sticky events; a new event beats a write-one clear in the same cycle
  wire [EVT_N-1:0] evt_set;
  assign evt_set[EVT_TESTER] = |(tester_irq_in & ~tester_sum_ff);
  assign evt_set[EVT_LINE] = |(line_unit_irq_in & ~line_sum_ff);
  assign evt_set[EVT_FRAME] = frame_pulse_ff;
  assign evt_set[EVT_RESET] = |(line_rst_pulse_ff | frm_rst_pulse_ff);
  wire [EVT_N-1:0] evt_clr = wr_evt_status ? wdata_in[EVT_N-1:0] : '0;
  wire [EVT_N-1:0] nxt_evt_status = (evt_status_ff & ~evt_clr) | evt_set;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      evt_status_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      evt_status_ff <= nxt_evt_status;
      irq_ff <= |(nxt_evt_status & evt_mask_ff);
    end
  end
  assign irq_out = irq_ff;

  // read mux; data stands only in the cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = RD_UNMAPPED;
    if (hit(addr_in, OFF_SYNC_LOSS)) begin
      rd_mux = sync_loss_ff;
    end else if (hit(addr_in, OFF_CLK_FREQ)) begin
      rd_mux = clk_freq_ff;
    end else if (hit(addr_in, OFF_LINE_RST)) begin
      rd_mux = line_rst_ff;
    end else if (hit(addr_in, OFF_FRM_RST)) begin
      rd_mux = frm_rst_ff;
    end else if (hit(addr_in, OFF_EVT_STATUS)) begin
      rd_mux = {{(8-EVT_N){1'b0}}, evt_status_ff};
    end else if (hit(addr_in, OFF_EVT_MASK)) begin
      rd_mux = {{(8-EVT_N){1'b0}}, evt_mask_ff};
    end else if (hit(addr_in, OFF_TESTER_SUM)) begin
      rd_mux = tester_sum_ff;
    end else if (hit(addr_in, OFF_LINE_SUM)) begin
      rd_mux = line_sum_ff;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rdata_ff <= RST_REG;
    end else begin
      rdata_ff <= rd_in ? rd_mux : RD_UNMAPPED;
    end
  end
  assign rdata_out = rdata_ff;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // checks guarding the logic above
  AST_SYNC_OUT_ONLY_DRIVEN: assert property (
    !sync_dir |=> !sync_pin_out)
    else $error("sync pin high while not driven");
  AST_SYNC_DIR_OE: assert property (
    $past(wr_sync_loss) |-> sync_pin_oe_n_out == !$past(wdata_in[BIT_SYNC_DIR]))
    else $error("sync pin direction not per written bit");
  AST_ALARM_LINE_LOSS: assert property (
    (loss_src && !freeze_select_in && $stable(loss_src)) |=>
      alarm_output_pins_out == $past(line_loss_in))
    else $error("alarm pins not line loss");
  AST_ALARM_FREEZE: assert property (
    freeze_select_in |=> alarm_output_pins_out == $past(sig_freeze_in))
    else $error("alarm pins not signalling freeze");
  AST_CLK_FIELDS: assert property (
    wr_clk_freq |=> {backplane_reference_select_out, backplane_frequency_select_out,
      frequency_select_out, master_period_select_out} == $past(wdata_in))
    else $error("clock fields not per write");
  AST_LINE_RST_PULSE: assert property (
    (wr_line_rst && wdata_in[0] && !line_rst_ff[0]) |=>
      line_unit_reset_pulse_out[0] ##1 !line_unit_reset_pulse_out[0])
    else $error("line reset start not one cycle");
  AST_RST_HELD: assert property (
    (framer_tester_reset_out[7] && !(wr_frm_rst && !wdata_in[7])) |=>
      framer_tester_reset_out[7])
    else $error("framer reset released without zero write");
  AST_FRM_RST_PULSE: assert property (
    framer_tester_reset_pulse_out[3] |-> framer_tester_reset_out[3] &&
      !$past(framer_tester_reset_out[3]))
    else $error("framer reset start without rising bit");
  AST_SUM_FOLLOW: assert property (
    $fell(line_unit_irq_in[7]) |=> !line_sum_ff[7])
    else $error("line summary bit did not fall");
  AST_SUM_WRITE_IGNORED: assert property (
    (wr_in && hit(addr_in, OFF_TESTER_SUM) && $stable(tester_irq_in)) |=>
      tester_sum_ff == $past(tester_sum_ff))
    else $error("tester summary changed by write");
  AST_READ_ONE_CYCLE: assert property (
    (rd_in && hit(addr_in, OFF_TESTER_SUM)) |=> rdata_out == $past(tester_sum_ff)
      ##1 ($past(rd_in) || rdata_out == RD_UNMAPPED))
    else $error("tester summary read wrong");
  AST_EVT_SET_WINS: assert property (
    (evt_set[EVT_LINE] && wr_evt_status) |=> evt_status_ff[EVT_LINE])
    else $error("event lost against clear");

  // frame generation, alarm selection, clock field, soft reset and summary checks
  AST_BP_RISE_SINGLE: assert property (
    bp_rise |=> !bp_rise)
    else $error("backplane edge counted twice");
  AST_SYNC_STEADY: assert property (
    (sync_dir && !bp_rise) |=> sync_pin_out == $past(sync_pin_out))
    else $error("sync pin moved between backplane edges");
  AST_SYNC_AT_WRAP: assert property (
    (sync_dir && bp_rise && frame_wrap) |=> sync_pin_out && frame_pulse_out)
    else $error("no frame pulse at count wrap");
  AST_EXT_FRAME: assert property (
    (!sync_dir && sync_in_rise) |=> frame_pulse_out)
    else $error("outside pulse gave no frame mark");
  AST_ALARM_FRAMER_LOSS: assert property (
    (!loss_src && !freeze_select_in) |=> alarm_output_pins_out == $past(framer_loss_in))
    else $error("alarm pins not framer loss");
  AST_CLK_HELD: assert property (
    !wr_clk_freq |=> $stable({frequency_select_out, backplane_frequency_select_out,
      master_period_select_out, backplane_reference_select_out}))
    else $error("clock fields moved without a write");
  AST_FRM_RST_START: assert property (
    (wr_frm_rst && wdata_in[7] && !frm_rst_ff[7]) |=>
      framer_tester_reset_pulse_out[7] && framer_tester_reset_out[7])
    else $error("framer reset start missing");
  AST_LINE_RST_LEVEL: assert property (
    wr_line_rst |=> line_unit_reset_out == $past(wdata_in))
    else $error("line reset level not per write");
  AST_TESTER_FOLLOW: assert property (
    !$past(reset_in) |-> tester_sum_ff == $past(tester_irq_in))
    else $error("tester summary not following source");
  AST_LINE_SUM_READ: assert property (
    (rd_in && hit(addr_in, OFF_LINE_SUM)) |=> rdata_out == $past(line_sum_ff))
    else $error("line summary read wrong");
  AST_LINE_BIT7: assert property (
    line_unit_irq_in[7] |=> line_sum_ff[7])
    else $error("line unit 8 interrupt not shown");

  // independent count of backplane rises between generated frame marks;
  // a clock write or input mode restarts it, as the old spacing no longer holds
  logic [8:0] rise_cnt_ff;
  logic rise_cnt_ok_ff;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !sync_dir || wr_clk_freq) begin
      rise_cnt_ff <= FRAME_CNT_RST;
      rise_cnt_ok_ff <= 1'b0;
    end else if (bp_rise) begin
      rise_cnt_ff <= gen_frame ? FRAME_CNT_RST : 9'(rise_cnt_ff + 9'd1);
      rise_cnt_ok_ff <= rise_cnt_ok_ff || gen_frame;
    end
  end
  AST_FRAME_SPACING: assert property (
    (gen_frame && rise_cnt_ok_ff) |-> rise_cnt_ff == frame_len - 9'd1)
    else $error("frame spacing not one frame period");

endmodule
